// ==== common/rtc_cfg.svh ====
/*
 * Register offsets, field positions, reset values and timing figures of the real-time clock.
 * Assumes a byte-addressed register port with one aligned 32-bit word per register.
 */
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define RTC_O_TIME 8'h00
`define RTC_O_DATE 8'h04
`define RTC_O_SUBS 8'h08
`define RTC_O_CTRL 8'h0c
`define RTC_O_STAT 8'h10
`define RTC_O_MASK 8'h14
`define RTC_O_ALMA 8'h18
`define RTC_O_ALMB 8'h1c
`define RTC_O_WUT 8'h20
`define RTC_O_CAL 8'h24
`define RTC_O_SHIFT 8'h28
`define RTC_O_TST 8'h2c
`define RTC_O_TSD 8'h30
`define RTC_O_BKP0 8'h40
`define RTC_BKP_N 5

// ****************************************
// control fields
// ****************************************
`define RTC_C_EN 0
`define RTC_C_FMT12 1
`define RTC_C_SRC 2
`define RTC_C_REFEN 4
`define RTC_C_REF60 5
`define RTC_C_WUEN 6
`define RTC_C_WUSEL 7
`define RTC_C_ALAEN 10
`define RTC_C_ALBEN 11
`define RTC_C_TSEN 12
`define RTC_C_TAMPEN 13
`define RTC_C_TAMPTS 15
`define RTC_C_FILT 16

// ****************************************
// status fields, one per event
// ****************************************
`define RTC_S_ALA 0
`define RTC_S_ALB 1
`define RTC_S_WUT 2
`define RTC_S_TS 3
`define RTC_S_TAMP 4
`define RTC_S_W 6

// ****************************************
// reset values and counts
// ****************************************
`define RTC_CTRL_RST 32'h0000_0001
`define RTC_DAY_RST 8'h01
`define RTC_WDAY_RST 3'h1
`define RTC_PRESCALE 16'h7fff
`define RTC_REF_DIV50 6'h32
`define RTC_REF_DIV60 6'h3c
`define RTC_CLK_NS 4
`define RTC_WAKE_EXIT_NS 60000
`define RTC_WAKE_EXIT_CYC (`RTC_WAKE_EXIT_NS / `RTC_CLK_NS)

`endif

// ==== common/rtc_pkg.sv ====
/*
 * Types shared by the real-time clock modules.
 * Assumes the constants header is included by the files that need numbers.
 */
package rtc_pkg;
    typedef enum logic [1:0] {
        SRC_XTAL = 2'b00,
        SRC_BYPASS = 2'b01,
        SRC_RC = 2'b10,
        SRC_HSE = 2'b11
    } clk_src_t;

    typedef struct packed {
        logic lvl;
        logic [3:0] cnt;
        logic stable;
        logic evt;
    } flt_st_t;

    typedef struct packed {
        logic [15:0] div;
        logic [19:0] cal;
        logic [14:0] shift;
        logic add1s;
        logic ref_q;
        logic [5:0] refcnt;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic pm;
        logic [2:0] wday;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
        logic [31:0] ctrl;
        logic [5:0] sr;
        logic [5:0] imr;
        logic [31:0] ala;
        logic [31:0] alb;
        logic [15:0] wut;
        logic [15:0] wucnt;
        logic [3:0] wudiv;
        logic [15:0] calr;
        logic [31:0] tst;
        logic [31:0] tsd;
        logic [31:0] rd;
        logic irq;
        logic wake;
    } rtc_st_t;
endpackage

// ==== common/evt_if.sv ====
/*
 * Carrier between the clock core and one pin event filter.
 * Assumes both ends run on the same system clock.
 */
interface evt_if;
    logic pin;
    logic sample;
    logic [1:0] filt;
    logic evt;
    modport filt_end(input pin, input sample, input filt, output evt);
    modport core_end(output pin, output sample, output filt, input evt);
endinterface

// ==== hdl/ev_filter.sv ====
/*
 * Pin event filter: a rising edge, or with filtering a high level held for 2, 4 or 8 samples.
 * Assumes the pin is synchronous to clk_sys and sample is a one-cycle strobe.
 */
module ev_filter (
    input wire logic clk_sys,
    input wire logic rst,
    evt_if.filt_end port
);
    rtc_pkg::flt_st_t st_r;
    rtc_pkg::flt_st_t st_nxt;
    logic [3:0] lim;

    always_comb begin
        st_nxt = st_r;
        lim = 4'h1 << port.filt;
        if (port.filt == 2'h0) begin
            st_nxt.stable = port.pin;
        end else if (port.sample) begin
            if (port.pin != st_r.lvl) begin
                st_nxt.lvl = port.pin;
                st_nxt.cnt = 4'h1;
            end else if (st_r.cnt < lim) begin
                st_nxt.cnt = st_r.cnt + 4'h1;
            end
            // glitches shorter than the window never reach stable
            if (st_nxt.cnt == lim) begin
                st_nxt.stable = st_nxt.lvl;
            end
        end
        st_nxt.evt = st_nxt.stable & ~st_r.stable;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port.evt = st_r.evt;
endmodule

// ==== hdl/rtc_core.sv ====
/*
 * Low-power real-time clock with BCD calendar, two alarms, wakeup timer, shift and
 * calibration, reference seconds, two tamper pins, timestamp and five backup words.
 * Assumes oscillator ticks and pins arrive as signals synchronous to clk_sys.
 */
// Summary of operation
// - Five 32-bit backup words give twenty bytes that software reads and writes freely.
// - Backup words are untouched by system reset and by a wake from standby.
// - The calendar keeps seconds to year in BCD and sub-seconds as a binary count, hours in 12- or 24-hour form.
// - The date rolls over at 28, 29 in leap years, 30 or 31 days without software help.
// - Two programmable alarms each raise an event that can wake the device.
// - A periodic wakeup timer with chosen resolution and period raises wake events.
// - Software can shift the running clock by 1 to 32767 pulses on the fly.
// - When enabled, a 50 or 60 Hz reference supplies the seconds.
// - Digital calibration corrects the counting rate in steps of about 1 ppm.
// - Two tamper pins pass a programmable filter and raise wake-capable events.
// - A timestamp pin event or a tamper event captures the calendar and can wake.
// - The count source is the crystal, an external oscillator, the internal RC or the fast clock.
// - Low-power modes do not halt the clock; only software stops it.
// - Alarm, tamper, timestamp and wakeup events request a standby exit within 60 us.
`include "rtc_cfg.svh"

module rtc_core #(
    parameter int WAKE_EXIT_CYC = `RTC_WAKE_EXIT_CYC,
    parameter logic [15:0] PRESCALE = `RTC_PRESCALE
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic tick_low_speed_external_crystal,
    input wire logic tick_low_speed_internal_rc,
    input wire logic tick_high_speed_external_clock,
    input wire logic ref_in,
    input wire logic [1:0] tamper_in,
    input wire logic ts_in,
    output logic irq,
    output logic wake
);
    rtc_pkg::rtc_st_t s;
    rtc_pkg::rtc_st_t n;
    logic [31:0] bkp_mem [`RTC_BKP_N];
    logic [2:0] ev, pin_vec;
    logic raw, mask_t, sec_tick, pre_sec, ref_sec, wu_step, ts_trig;
    logic [1:0] step;
    logic [15:0] div_sum;
    logic [5:0] set, clr;
    logic [31:0] time_w, date_w;
    logic [5:0] ref_div;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic bkp_hit(input logic [7:0] a);
        bkp_hit = (a[7:5] == 3'h2) && (a[1:0] == 2'h0) && (a[4:2] < 3'(`RTC_BKP_N));
    endfunction

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02: last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
    endfunction

    function automatic logic alm_match(input logic [31:0] al, input rtc_pkg::rtc_st_t c);
        alm_match = (al[7] || al[6:0] == c.sec[6:0]) && (al[15] || al[14:8] == c.min[6:0])
                 && (al[23] || al[21:16] == c.hour[5:0]) && (al[31] || al[29:24] == c.date[5:0]);
    endfunction

    function automatic logic src_tick(input rtc_pkg::clk_src_t src, input logic l,
                                      input logic r, input logic h);
        case (src)
            rtc_pkg::SRC_XTAL, rtc_pkg::SRC_BYPASS: src_tick = l;
            rtc_pkg::SRC_RC: src_tick = r;
            default: src_tick = h;
        endcase
    endfunction

    // ****************************************
    // pin event filters
    // ****************************************
    // one vector so every filter index stays inside its source
    assign pin_vec = {ts_in, tamper_in};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ev
            evt_if u_if();
            assign u_if.pin = pin_vec[g];
            assign u_if.sample = raw;
            assign u_if.filt = (g < 2) ? s.ctrl[`RTC_C_FILT+1:`RTC_C_FILT] : 2'h0;
            assign ev[g] = u_if.evt;
            ev_filter u_flt (
                .clk_sys(clk_sys),
                .rst(rst),
                .port(u_if.filt_end)
            );
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = s;
        n.rd = '0;
        set = '0;
        clr = '0;
        time_w = {9'h0, s.pm, s.hour[5:0], 1'b0, s.min[6:0], 1'b0, s.sec[6:0]};
        date_w = {8'h0, s.year, s.wday, s.month[4:0], 2'h0, s.date[5:0]};
        // power modes are not inputs here: the count runs until the enable bit drops
        raw = s.ctrl[`RTC_C_EN] && src_tick(rtc_pkg::clk_src_t'(s.ctrl[`RTC_C_SRC+1:`RTC_C_SRC]),
              tick_low_speed_external_crystal, tick_low_speed_internal_rc,
              tick_high_speed_external_clock);

        // window of 2^20 ticks; each mask or insert moves the rate by about 1 ppm
        if (raw) begin
            n.cal = s.cal + 20'h1;
        end
        mask_t = raw && s.cal[10:0] == 11'h0 && s.cal[19:11] < s.calr[8:0];
        step = '0;
        if (raw && s.shift != 15'h0) begin
            n.shift = s.shift - 15'h1;
        end else if (raw && !mask_t) begin
            step = (s.cal[10:0] == 11'h0 && s.calr[15]) ? 2'h2 : 2'h1;
        end
        div_sum = s.div + {14'h0, step};
        pre_sec = div_sum > PRESCALE;
        n.div = pre_sec ? div_sum - PRESCALE - 16'h1 : div_sum;

        n.ref_q = ref_in;
        ref_sec = 1'b0;
        ref_div = s.ctrl[`RTC_C_REF60] ? `RTC_REF_DIV60 : `RTC_REF_DIV50;
        if (s.ctrl[`RTC_C_REFEN] && ref_in && !s.ref_q) begin
            if (s.refcnt + 6'h1 == ref_div) begin
                n.refcnt = '0;
                ref_sec = 1'b1;
                n.div = '0;
            end else begin
                n.refcnt = s.refcnt + 6'h1;
            end
        end
        sec_tick = s.ctrl[`RTC_C_EN] && ((s.ctrl[`RTC_C_REFEN] ? ref_sec : pre_sec) || s.add1s);
        if (sec_tick) begin
            n.add1s = 1'b0;
        end

        // ****************************************
        // calendar advance
        // ****************************************
        if (sec_tick) begin
            n.sec = bcd_inc(s.sec);
            if (s.sec == 8'h59) begin
                n.sec = '0;
                n.min = bcd_inc(s.min);
                if (s.min == 8'h59) begin
                    n.min = '0;
                    n.hour = bcd_inc(s.hour);
                    if (!s.ctrl[`RTC_C_FMT12] && s.hour == 8'h23) begin
                        n.hour = '0;
                    end else if (s.ctrl[`RTC_C_FMT12] && s.hour == 8'h12) begin
                        n.hour = 8'h01;
                    end else if (s.ctrl[`RTC_C_FMT12] && s.hour == 8'h11) begin
                        n.pm = ~s.pm;
                    end
                    if ((!s.ctrl[`RTC_C_FMT12] && s.hour == 8'h23) ||
                        (s.ctrl[`RTC_C_FMT12] && s.hour == 8'h11 && s.pm)) begin
                        n.wday = (s.wday == 3'h7) ? 3'h1 : s.wday + 3'h1;
                        n.date = bcd_inc(s.date);
                        if (s.date == last_day(s.month, s.year)) begin
                            n.date = 8'h01;
                            n.month = bcd_inc(s.month);
                            if (s.month == 8'h12) begin
                                n.month = 8'h01;
                                n.year = (s.year == 8'h99) ? 8'h00 : bcd_inc(s.year);
                            end
                        end
                    end
                end
            end
            set[`RTC_S_ALA] = s.ctrl[`RTC_C_ALAEN] && alm_match(s.ala, n);
            set[`RTC_S_ALB] = s.ctrl[`RTC_C_ALBEN] && alm_match(s.alb, n);
        end

        // ****************************************
        // wakeup timer
        // ****************************************
        if (raw) begin
            n.wudiv = s.wudiv + 4'h1;
        end
        case (s.ctrl[`RTC_C_WUSEL+2:`RTC_C_WUSEL])
            3'h0: wu_step = raw && (&s.wudiv[3:0]);
            3'h1: wu_step = raw && (&s.wudiv[2:0]);
            3'h2: wu_step = raw && (&s.wudiv[1:0]);
            3'h3: wu_step = raw && s.wudiv[0];
            default: wu_step = sec_tick;
        endcase
        if (wu_step && s.ctrl[`RTC_C_WUEN]) begin
            if (s.wucnt == 16'h0) begin
                n.wucnt = s.wut;
                set[`RTC_S_WUT] = 1'b1;
            end else begin
                n.wucnt = s.wucnt - 16'h1;
            end
        end

        // ****************************************
        // tamper and timestamp
        // ****************************************
        set[`RTC_S_TAMP+1:`RTC_S_TAMP] = ev[1:0] & s.ctrl[`RTC_C_TAMPEN+1:`RTC_C_TAMPEN];
        ts_trig = (ev[2] && s.ctrl[`RTC_C_TSEN]) ||
                  (s.ctrl[`RTC_C_TAMPTS] && (|set[`RTC_S_TAMP+1:`RTC_S_TAMP]));
        if (ts_trig) begin
            n.tst = time_w;
            n.tsd = date_w;
            set[`RTC_S_TS] = 1'b1;
        end

        // ****************************************
        // register port
        // ****************************************
        if (wr_en) begin
            case (addr)
                `RTC_O_TIME: begin
                    n.sec = {1'b0, wr_data[6:0]};
                    n.min = {1'b0, wr_data[14:8]};
                    n.hour = {2'h0, wr_data[21:16]};
                    n.pm = wr_data[22];
                    n.div = '0;
                end
                `RTC_O_DATE: begin
                    n.date = {2'h0, wr_data[5:0]};
                    n.month = {3'h0, wr_data[12:8]};
                    n.wday = wr_data[15:13];
                    n.year = wr_data[23:16];
                end
                `RTC_O_CTRL: n.ctrl = wr_data;
                `RTC_O_STAT: clr = wr_data[`RTC_S_W-1:0];
                `RTC_O_MASK: n.imr = wr_data[`RTC_S_W-1:0];
                `RTC_O_ALMA: n.ala = wr_data;
                `RTC_O_ALMB: n.alb = wr_data;
                `RTC_O_WUT: begin
                    n.wut = wr_data[15:0];
                    n.wucnt = wr_data[15:0];
                end
                `RTC_O_CAL: n.calr = {wr_data[15], 6'h0, wr_data[8:0]};
                `RTC_O_SHIFT: begin
                    n.shift = wr_data[14:0];
                    n.add1s = wr_data[31];
                end
                default: ;
            endcase
        end
        if (rd_en) begin
            case (addr)
                `RTC_O_TIME: n.rd = time_w;
                `RTC_O_DATE: n.rd = date_w;
                `RTC_O_SUBS: n.rd = {16'h0, s.div};
                `RTC_O_CTRL: n.rd = s.ctrl;
                `RTC_O_STAT: n.rd = {26'h0, s.sr};
                `RTC_O_MASK: n.rd = {26'h0, s.imr};
                `RTC_O_ALMA: n.rd = s.ala;
                `RTC_O_ALMB: n.rd = s.alb;
                `RTC_O_WUT: n.rd = {16'h0, s.wut};
                `RTC_O_CAL: n.rd = {16'h0, s.calr};
                `RTC_O_SHIFT: n.rd = {s.add1s, 16'h0, s.shift};
                `RTC_O_TST: n.rd = s.tst;
                `RTC_O_TSD: n.rd = s.tsd;
                default: n.rd = bkp_hit(addr) ? bkp_mem[addr[4:2]] : 32'h0;
            endcase
        end
        // a new event outranks a clear written in the same cycle
        n.sr = (s.sr & ~clr) | set;
        n.irq = |(n.sr & n.imr);
        n.wake = |n.sr;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.ctrl <= `RTC_CTRL_RST;
            s.date <= `RTC_DAY_RST;
            s.month <= `RTC_DAY_RST;
            s.wday <= `RTC_WDAY_RST;
        end else begin
            s <= n;
        end
    end

    // no reset: the words must outlive system reset and standby exit
    always_ff @(posedge clk_sys) begin
        if (wr_en && bkp_hit(addr)) begin
            bkp_mem[addr[4:2]] <= wr_data;
        end
    end

    assign rd_data = s.rd;
    assign irq = s.irq;
    assign wake = s.wake;

    // ****************************************
    // checks
    // ****************************************
    logic [15:0] wait_cnt;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_cnt <= '0;
        end else begin
            wait_cnt <= (s.sr != '0 && !wake) ? wait_cnt + 16'h1 : '0;
        end
    end

    chk_bkp_readback: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && addr == `RTC_O_BKP0) ##1 (rd_en && !wr_en && addr == `RTC_O_BKP0)
        |=> rd_data == $past(wr_data, 2)) else $error("backup word readback wrong");
    chk_bkp_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !(wr_en && addr == `RTC_O_BKP0) |=> $stable(bkp_mem[0])) else $error("backup word changed");
    chk_sec_bcd: assert property (@(posedge clk_sys) disable iff (rst)
        sec_tick && s.sec == 8'h59 && !wr_en |=> s.sec == 8'h00) else $error("seconds did not wrap");
    chk_feb_roll: assert property (@(posedge clk_sys) disable iff (rst)
        sec_tick && !wr_en && s.sec == 8'h59 && s.min == 8'h59 && s.hour == 8'h23 && !s.ctrl[`RTC_C_FMT12]
        && s.month == 8'h02 && s.date == 8'h28 && s.year == 8'h01 |=> s.date == 8'h01 && s.month == 8'h03)
        else $error("february rollover wrong");
    chk_alarm_flag: assert property (@(posedge clk_sys) disable iff (rst)
        sec_tick && s.ctrl[`RTC_C_ALAEN] && alm_match(s.ala, n) |=> s.sr[`RTC_S_ALA][*2])
        else $error("alarm flag missing or not sticky");
    chk_wut_reload: assert property (@(posedge clk_sys) disable iff (rst)
        wu_step && s.ctrl[`RTC_C_WUEN] && s.wucnt == 16'h0 && !wr_en
        |=> s.sr[`RTC_S_WUT] && s.wucnt == $past(s.wut)) else $error("wakeup reload wrong");
    chk_tamper_flag: assert property (@(posedge clk_sys) disable iff (rst)
        ev[0] && s.ctrl[`RTC_C_TAMPEN] |=> s.sr[`RTC_S_TAMP] ##1 wake) else $error("tamper event lost");
    chk_ts_capture: assert property (@(posedge clk_sys) disable iff (rst)
        ev[2] && s.ctrl[`RTC_C_TSEN] |=> s.tst == $past(time_w) && s.sr[`RTC_S_TS])
        else $error("timestamp not captured");
    chk_wake_exit: assert property (@(posedge clk_sys) disable iff (rst)
        wait_cnt < WAKE_EXIT_CYC) else $error("wake request too late");
endmodule

// ==== dv/rtc_pins.sv ====
/*
 * Far side of the clock: oscillator tick lines, reference input, timestamp and tamper pins.
 * Assumes the bench picks the ticking line and calls the pin tasks off the clock edge.
 */
module rtc_pins (
    input wire logic clk_sys,
    output logic tick_xtal,
    output logic tick_rc,
    output logic tick_hse,
    output logic ref_in,
    output logic ts_in,
    output logic [1:0] tamper_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int line = 0;
    int cnt = 0;
    initial begin
        tick_xtal = 1'b0;
        tick_rc = 1'b0;
        tick_hse = 1'b0;
        ref_in = 1'b0;
        ts_in = 1'b0;
        tamper_in = 2'h0;
    end
    // one tick in eight cycles on a single line; line 3 silences all, so a wrong mux shows
    always @(posedge clk_sys) begin
        cnt <= (cnt + 1) % 8;
        tick_xtal <= (cnt == 0) && (line == 0);
        tick_rc <= (cnt == 0) && (line == 1);
        tick_hse <= (cnt == 0) && (line == 2);
    end
    task automatic pulse(input int which, input int len = 8);
        @(posedge clk_sys);
        if (which == 2) ts_in <= 1'b1;
        else tamper_in[which] <= 1'b1;
        repeat (len) @(posedge clk_sys);
        ts_in <= 1'b0;
        tamper_in <= 2'h0;
    endtask
    task automatic ref_edges(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            ref_in <= 1'b1;
            repeat (2) @(posedge clk_sys);
            ref_in <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
endmodule

// ==== dv/low_power_rtc_backup_tb.sv ====
/*
 * Self-checking bench of the real-time clock core, with the pin and oscillator model.
 * Assumes a four-tick second (PRESCALE 3) and the register map of the core.
 */
module low_power_rtc_backup_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] DIN [7] = '{32'h0001_2228, 32'h0004_2228, 32'h0004_2229,
        32'h0001_2430, 32'h0001_2131, 32'h0001_2130, 32'h0099_3231};
    localparam logic [31:0] DOUT [7] = '{32'h0001_4301, 32'h0004_4229, 32'h0004_4301,
        32'h0001_4501, 32'h0001_4201, 32'h0001_4131, 32'h0000_4101};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic [31:0] rd_data;
    logic [31:0] rdv;
    logic t_x, t_r, t_h, ref_p, ts_p, irq, wake;
    logic [1:0] tamp_p;
    int failures = 0;
    int checks = 0;
    always #2 clk_sys = ~clk_sys;
    rtc_pins pins (.clk_sys(clk_sys), .tick_xtal(t_x), .tick_rc(t_r), .tick_hse(t_h),
        .ref_in(ref_p), .ts_in(ts_p), .tamper_in(tamp_p));
    rtc_core #(.PRESCALE(16'h0003)) DUT (.clk_sys(clk_sys), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .tick_low_speed_external_crystal(t_x), .tick_low_speed_internal_rc(t_r),
        .tick_high_speed_external_clock(t_h), .ref_in(ref_p), .tamper_in(tamp_p),
        .ts_in(ts_p), .irq(irq), .wake(wake));
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 rdv = rd_data;
    endtask
    // write strobe drops and read strobe rises at one edge: no gap
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 rdv = rd_data;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rdv, exp);
    endtask
    // bounded: a register that never moves reports and ends the run
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        for (int n = 0; n < 400; n++) begin
            rd(a);
            if ((rdv & m) === v) begin
                chk(rdv & m, v);
                return;
            end
        end
        chk(32'hdead_0000, {24'h0, a});
        test_done();
    endtask
    task automatic iw_chk(input logic i, input logic w);
        repeat (2) @(posedge clk_sys);
        #1 chk({30'h0, irq, wake}, {30'h0, i, w});
    endtask
    task automatic bk_chk();
        for (int i = 0; i < 5; i++) begin
            rd_chk(8'h40 + 8'(4 * i), 32'ha5c3_0000 + 32'(i));
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        rd_chk(8'h0c, 32'h1);
        rd_chk(8'h04, 32'h0000_2101);
        rd_chk(8'h3c, 32'h0);
        iw_chk(1'b0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            wr(8'h40 + 8'(4 * i), 32'ha5c3_0000 + 32'(i));
        end
        bk_chk();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        bk_chk();
        wr_rd(8'h40, 32'h5a5a_0f0f);
        chk(rdv, 32'h5a5a_0f0f);
        $display("regs done");
    endtask
    task automatic t_cal();
        for (int i = 0; i < 7; i++) begin
            wr(8'h00, 32'h0023_5959);
            wr(8'h04, DIN[i]);
            poll(8'h00, 32'h7f, 32'h0);
            rd_chk(8'h00, 32'h0);
            rd_chk(8'h04, DOUT[i]);
        end
        wr(8'h0c, 32'h3);
        wr(8'h00, 32'h0011_5959);
        poll(8'h00, 32'h7f, 32'h0);
        rd_chk(8'h00, 32'h0052_0000);
        $display("calendar done");
    endtask
    task automatic t_src();
        for (int s = 0; s < 4; s++) begin
            pins.line = (s < 2) ? 0 : s - 1;
            wr(8'h0c, 32'h1 | 32'(s << 2));
            wr(8'h00, 32'h0);
            poll(8'h00, 32'h7f, 32'h1);
        end
        pins.line = 0;
        wr(8'h00, 32'h0);
        repeat (100) @(posedge clk_sys);
        rd_chk(8'h00, 32'h0);
        // a shift of 8 swallows every tick of the next 60 cycles
        wr(8'h0c, 32'h1);
        wr(8'h00, 32'h0);
        wr(8'h28, 32'h8);
        repeat (60) @(posedge clk_sys);
        rd_chk(8'h00, 32'h0);
        poll(8'h00, 32'h7f, 32'h1);
        $display("source done");
    endtask
    task automatic t_ref();
        pins.line = 3;
        for (int k = 0; k < 2; k++) begin
            wr(8'h0c, 32'h11 | 32'(k << 5));
            wr(8'h00, 32'h0);
            pins.ref_edges(k ? 59 : 49);
            rd_chk(8'h00, 32'h0);
            pins.ref_edges(1);
            repeat (3) @(posedge clk_sys);
            rd_chk(8'h00, 32'h1);
        end
        pins.line = 0;
        $display("reference done");
    endtask
    task automatic t_alarm();
        for (int i = 0; i < 2; i++) begin
            wr(8'h14, 32'h0);
            wr(8'h10, 32'h3f);
            wr(8'h18 + 8'(4 * i), 32'h8080_8002);
            wr(8'h0c, 32'h1 | (32'h400 << i));
            wr(8'h00, 32'h0);
            poll(8'h10, 32'h3, 32'(1 << i));
            iw_chk(1'b0, 1'b1);
            wr(8'h14, 32'(1 << i));
            iw_chk(1'b1, 1'b1);
            wr(8'h10, 32'(1 << i));
            iw_chk(1'b0, 1'b0);
        end
        $display("alarm done");
    endtask
    task automatic t_wut();
        wr(8'h20, 32'h3);
        wr(8'h0c, 32'h41);
        wr(8'h10, 32'h3f);
        poll(8'h10, 32'h4, 32'h4);
        wr(8'h10, 32'h4);
        rd_chk(8'h10, 32'h0);
        poll(8'h10, 32'h4, 32'h4);
        iw_chk(1'b0, 1'b1);
        $display("wakeup done");
    endtask
    task automatic t_pins();
        wr(8'h0c, 32'h0);
        wr(8'h10, 32'h3f);
        wr(8'h00, 32'h0012_3456);
        pins.pulse(2);
        rd_chk(8'h10, 32'h0);
        wr(8'h0c, 32'h1000);
        pins.pulse(2);
        poll(8'h10, 32'h3f, 32'h8);
        rd_chk(8'h2c, 32'h0012_3456);
        iw_chk(1'b0, 1'b1);
        for (int j = 0; j < 2; j++) begin
            wr(8'h10, 32'h3f);
            wr(8'h0c, 32'he000);
            pins.pulse(j);
            poll(8'h10, 32'h3f, 32'h8 | (32'h10 << j));
        end
        // filter of two samples: one tick inside a short pulse is a glitch
        wr(8'h10, 32'h3f);
        wr(8'h0c, 32'h0001_2001);
        pins.pulse(0);
        rd_chk(8'h10, 32'h0);
        pins.pulse(0, 40);
        poll(8'h10, 32'h10, 32'h10);
        $display("pins done");
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_cal();
        t_src();
        t_ref();
        t_alarm();
        t_wut();
        t_pins();
        test_done();
    end
endmodule
